// ---- core/lclf_core.sv ----
// Current-limit motor-lock detector with configurable response.
// Assumes comparator trip arrives asynchronously; ADC samples and
// configuration writes come from logic on clk_in.
`timescale 1ns/1ns

// Summary of operation
// R1: Bits 26-23 pick comparator lock limit, 0.078125 A to 5.0 A table.
// R2: Bits 22-19 pick ADC lock threshold from the same current table.
// R3: Mode 0h or 1h: latch fault, assert indicator, tristate outputs.
// R4: Mode 2h: latch fault, assert indicator, high-side brake.
// R5: Mode 3h: latch fault, assert indicator, low-side brake.
// R6: Mode 4h/5h: tristate, auto clear after retry time, latch past limit.
// R7: Mode 6h: high-side brake, indicator on, auto clear up to limit.
// R8: Mode 7h: low-side brake, auto clear, latch past retry limit.
// R9: Mode 8h: report on indicator only, output stage untouched.
// R10: Modes 9h, Ah, Ch: detection fully disabled.
// R11: Bits 14-11 pick filter time, 0.05 ms to 1000 ms.
// R12: Bits 10-7 pick retry wait, 300 ms to 14 s.
// R13: Lock only when current stays above threshold for full filter time.
// R14: Comparator and ADC paths both feed the same response.
module lclf_core
  import lclf_pkg::*;
#(
  parameter int P_TICK_CYC = TICK_CYC
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // Configuration word access
  input  wire logic              cfg_wr_in,
  input  wire logic [CFG_W-1:0]  cfg_wdata_in,
  output logic      [CFG_W-1:0]  cfg_rdata_out,
  // Retry limit and fault clear
  input  wire logic [RCNT_W-1:0] retry_attempt_limit_in,
  input  wire logic              fault_clear_in,
  // Current sensing
  input  wire logic              comp_trip_in,
  input  wire logic              adc_valid_in,
  input  wire logic [ADC_W-1:0]  adc_current_in,
  output logic      [3:0]        comp_limit_code_out,
  // Fault and output stage
  output logic                   fault_indicator_n_out,
  output logic      [1:0]        gate_mode_out,
  output logic                   lock_latched_out,
  output logic      [RCNT_W-1:0] retry_count_out
);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RETRY  = 2'b01,
    ST_LATCH  = 2'b10,
    ST_REPORT = 2'b11
  } lclf_state_t;

  lclf_cfg_t             cfg;
  lclf_state_t           state;
  lclf_state_t           next_state;
  logic                  trip_s1;
  logic                  trip_s2;
  logic                  adc_over;
  logic [15:0]           tick_cnt;
  logic                  tick;
  logic [CNT_W-1:0]      filt_cnt;
  logic [CNT_W-1:0]      next_filt_cnt;
  logic [CNT_W-1:0]      wait_cnt;
  logic [CNT_W-1:0]      next_wait_cnt;
  logic [RCNT_W-1:0]     retry_cnt;
  logic [RCNT_W-1:0]     next_retry_cnt;

  // Field decode
  wire logic [3:0]       mode = cfg.lock_mode;
  wire logic             mode_latch = (mode <= 4'h3);
  wire logic             mode_retry = (mode >= 4'h4) && (mode <= 4'h7);
  wire logic             mode_report = (mode == 4'h8);
  wire logic             mode_on = mode_latch | mode_retry | mode_report; // R10
  wire logic [ADC_W-1:0] adc_thr = lclf_thr(cfg.adc_lock_threshold); // R2
  wire logic [CNT_W-1:0] filt_ticks =
    CNT_W'(lclf_filt_us(cfg.current_lock_filter_time) / TICK_US); // R11
  wire logic [CNT_W-1:0] retry_ticks =
    CNT_W'(lclf_retry_ms(cfg.lock_retry_interval) * (1000 / TICK_US)); // R12

  // Either path flags overcurrent
  wire logic             over = trip_s2 | adc_over; // R14
  wire logic             filt_done = over && (filt_cnt >= filt_ticks); // R13
  wire logic             lock_evt = mode_on && (state == ST_IDLE) && filt_done;
  wire logic             wait_done = tick && (wait_cnt >= retry_ticks);
  wire logic             over_limit = (retry_cnt >= retry_attempt_limit_in);

  function automatic logic [1:0] gate_of(input logic [3:0] m);
    case (m)
      4'h2, 4'h6: gate_of = GATE_HSB;
      4'h3, 4'h7: gate_of = GATE_LSB;
      default:    gate_of = GATE_HIZ;
    endcase
  endfunction

  wire logic [1:0]       next_gate =
    (next_state == ST_RETRY || next_state == ST_LATCH) ? gate_of(mode) : GATE_RUN;

  // Configuration register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg <= lclf_cfg_t'(CFG_RESET);
    end else if (cfg_wr_in) begin
      cfg <= lclf_cfg_t'(cfg_wdata_in & CFG_RMASK);
    end
  end

  // Comparator trip synchroniser
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trip_s1 <= 1'b0;
      trip_s2 <= 1'b0;
    end else begin
      trip_s1 <= comp_trip_in;
      trip_s2 <= trip_s1;
    end
  end

  // ADC threshold compare, held between samples
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      adc_over <= 1'b0;
    end else if (adc_valid_in) begin
      adc_over <= (adc_current_in > adc_thr); // R2
    end
  end

  // Timebase tick
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt <= 16'h0000;
    end else if (tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end
  assign tick = (tick_cnt >= 16'(P_TICK_CYC - 1));

  // Filter counter restarts on any dip below threshold
  always_comb begin
    next_filt_cnt = filt_cnt;
    if (!over || !mode_on || state != ST_IDLE) begin
      next_filt_cnt = '0; // R13
    end else if (tick && !filt_done) begin
      next_filt_cnt = filt_cnt + CNT_W'(1);
    end
  end

  // Response state machine
  always_comb begin
    next_state     = state;
    next_wait_cnt  = wait_cnt;
    next_retry_cnt = retry_cnt;
    case (state)
      ST_IDLE: begin
        next_wait_cnt = '0;
        if (lock_evt) begin
          if (mode_latch) begin
            next_state = ST_LATCH; // R3 R4 R5
          end else if (mode_report) begin
            next_state = ST_REPORT; // R9
          end else if (over_limit) begin
            next_state = ST_LATCH; // R6 R7 R8
          end else begin
            next_state     = ST_RETRY; // R6 R7 R8
            next_retry_cnt = retry_cnt + RCNT_W'(1);
          end
        end else if (fault_clear_in) begin
          next_retry_cnt = '0;
        end
      end
      ST_RETRY: begin
        if (wait_done) begin
          next_state    = ST_IDLE; // R6 R7 R8
          next_wait_cnt = '0;
        end else if (tick) begin
          next_wait_cnt = wait_cnt + CNT_W'(1); // R12
        end
      end
      ST_LATCH, ST_REPORT: begin
        if (fault_clear_in) begin
          next_state     = ST_IDLE;
          next_retry_cnt = '0;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!mode_on) begin
      next_state    = ST_IDLE; // R10
      next_wait_cnt = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state     <= ST_IDLE;
      filt_cnt  <= '0;
      wait_cnt  <= '0;
      retry_cnt <= '0;
    end else begin
      state     <= next_state;
      filt_cnt  <= next_filt_cnt;
      wait_cnt  <= next_wait_cnt;
      retry_cnt <= next_retry_cnt;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fault_indicator_n_out <= 1'b1;
      gate_mode_out         <= GATE_RUN;
      lock_latched_out      <= 1'b0;
      retry_count_out       <= '0;
      comp_limit_code_out   <= 4'h0;
      cfg_rdata_out         <= CFG_RESET;
    end else begin
      fault_indicator_n_out <= (next_state == ST_IDLE); // R3 R7 R9
      gate_mode_out         <= next_gate; // R4 R5 R7 R8
      lock_latched_out      <= (next_state == ST_LATCH);
      retry_count_out       <= next_retry_cnt;
      comp_limit_code_out   <= cfg.comparator_lock_current_limit; // R1
      cfg_rdata_out         <= cfg;
    end
  end

endmodule // lclf_core

// ---- core/lclf_pkg.sv ----
// Constants, types and lookup functions for the current-limit lock unit.
// Assumes a 250 MHz core clock and a 10 us timebase tick.
package lclf_pkg;

  // Clock and timebase
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_US       = 10;
  localparam int TICK_CYC      = (TICK_US * 1000) / CLK_PERIOD_NS;

  // Configuration word layout
  localparam int CFG_W         = 32;
  localparam int CMP_LIM_LSB   = 23;
  localparam int ADC_LIM_LSB   = 19;
  localparam int MODE_LSB      = 15;
  localparam int FILT_LSB      = 11;
  localparam int RETRY_LSB     = 7;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [31:0] CFG_RMASK = 32'h7FFFFFFF;

  // Widths of the detection path
  localparam int ADC_W         = 12;
  localparam int CNT_W         = 21;
  localparam int RCNT_W        = 4;

  typedef struct packed {
    logic       rsvd;
    logic [3:0] torque_ref;
    logic [3:0] comparator_lock_current_limit;
    logic [3:0] adc_lock_threshold;
    logic [3:0] lock_mode;
    logic [3:0] current_lock_filter_time;
    logic [3:0] lock_retry_interval;
    logic [6:0] other;
  } lclf_cfg_t;

  // Output stage requests
  typedef enum logic [1:0] {
    GATE_RUN = 2'b00,
    GATE_HIZ = 2'b01,
    GATE_HSB = 2'b10,
    GATE_LSB = 2'b11
  } lclf_gate_t;

  // Threshold in units of 1/128 A (0.078125 A = 10)
  function automatic logic [ADC_W-1:0] lclf_thr(input logic [3:0] c);
    case (c)
      4'h0: lclf_thr = 12'h00A;
      4'h1: lclf_thr = 12'h014;
      4'h2: lclf_thr = 12'h028;
      4'h3: lclf_thr = 12'h050;
      4'h4: lclf_thr = 12'h078;
      4'h5: lclf_thr = 12'h0A0;
      4'h6: lclf_thr = 12'h0C8;
      4'h7: lclf_thr = 12'h0F0;
      4'h8: lclf_thr = 12'h118;
      4'h9: lclf_thr = 12'h140;
      4'hA: lclf_thr = 12'h168;
      4'hB: lclf_thr = 12'h190;
      4'hC: lclf_thr = 12'h1B8;
      4'hD: lclf_thr = 12'h1E0;
      4'hE: lclf_thr = 12'h230;
      default: lclf_thr = 12'h280;
    endcase
  endfunction

  // Filter time in microseconds
  function automatic int lclf_filt_us(input logic [3:0] c);
    case (c)
      4'h0: lclf_filt_us = 50;
      4'h1: lclf_filt_us = 100;
      4'h2: lclf_filt_us = 200;
      4'h3: lclf_filt_us = 500;
      4'h4: lclf_filt_us = 1000;
      4'h5: lclf_filt_us = 2500;
      4'h6: lclf_filt_us = 5000;
      4'h7: lclf_filt_us = 7500;
      4'h8: lclf_filt_us = 10000;
      4'h9: lclf_filt_us = 25000;
      4'hA: lclf_filt_us = 50000;
      4'hB: lclf_filt_us = 75000;
      4'hC: lclf_filt_us = 100000;
      4'hD: lclf_filt_us = 200000;
      4'hE: lclf_filt_us = 500000;
      default: lclf_filt_us = 1000000;
    endcase
  endfunction

  // Retry interval in milliseconds
  function automatic int lclf_retry_ms(input logic [3:0] c);
    case (c)
      4'h0: lclf_retry_ms = 300;
      4'h1: lclf_retry_ms = 500;
      default: lclf_retry_ms = (int'(c) - 1) * 1000;
    endcase
  endfunction

endpackage

// ---- verif/lclf_core_properties.sv ----
// Port checker for the lock unit.
// Assumes it is bound to lclf_core.
`timescale 1ns/1ns
module lclf_core_properties
  import lclf_pkg::*;
(
  // Watched ports
  input wire logic              clk_in,
  input wire logic              rst_b_in,
  input wire logic              cfg_wr_in,
  input wire logic [CFG_W-1:0]  cfg_wdata_in,
  input wire logic [CFG_W-1:0]  cfg_rdata_out,
  input wire logic [RCNT_W-1:0] retry_attempt_limit_in,
  input wire logic              fault_clear_in,
  input wire logic [3:0]        comp_limit_code_out,
  input wire logic              fault_indicator_n_out,
  input wire logic [1:0]        gate_mode_out,
  input wire logic              lock_latched_out,
  input wire logic [RCNT_W-1:0] retry_count_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  wire [3:0] mode     = cfg_rdata_out[MODE_LSB+:4];
  wire [1:0] exp_gate = mode[3] ? GATE_RUN : (mode[1] ? {1'b1, mode[0]} : GATE_HIZ);
  AST_CFG_ECHO: assert property (cfg_wr_in |=> ##1 cfg_rdata_out == ($past(cfg_wdata_in, 2) & CFG_RMASK))
    else $error("config readback wrong");
  AST_LIMIT_CODE: assert property (cfg_wr_in |=> ##1 comp_limit_code_out == $past(cfg_wdata_in[CMP_LIM_LSB+:4], 2))
    else $error("limit code wrong");
  AST_DISABLED: assert property ((mode > 4'h8) [*3] |-> fault_indicator_n_out && gate_mode_out == GATE_RUN)
    else $error("disabled mode acted");
  AST_FAULT_GATE: assert property (!fault_indicator_n_out && mode <= 4'h8 |-> gate_mode_out == exp_gate)
    else $error("gate action wrong");
  AST_LATCH_IND: assert property (lock_latched_out |-> !fault_indicator_n_out && gate_mode_out != GATE_RUN)
    else $error("latched without fault");
  AST_CLEAR_ONLY: assert property ($fell(lock_latched_out) |-> $past(fault_clear_in))
    else $error("latch dropped alone");
  AST_CLEAR_EFFECT: assert property (fault_clear_in |-> ##3 retry_count_out == 4'h0 && !lock_latched_out)
    else $error("clear ignored");
  AST_RETRY_LIMIT: assert property (retry_count_out <= retry_attempt_limit_in)
    else $error("retry count over limit");
  cover property ($rose(lock_latched_out));
  cover property (retry_count_out != 4'h0);
  cover property (gate_mode_out == GATE_HSB);
endmodule // lclf_core_properties
bind lclf_core lclf_core_properties u_lclf_core_properties (.clk_in, .rst_b_in, .cfg_wr_in, .cfg_wdata_in,
  .cfg_rdata_out, .retry_attempt_limit_in, .fault_clear_in, .comp_limit_code_out, .fault_indicator_n_out,
  .gate_mode_out, .lock_latched_out, .retry_count_out);

// ---- verif/lclf_stage_model.sv ----
// Power stage model: phase current and its two sense paths.
// Assumes the unit's gate request and comparator limit code.
`timescale 1ns/1ns
module lclf_stage_model
  import lclf_pkg::*;
(
  // Clock and requests
  input  wire logic             clk_in,
  input  wire logic [1:0]       gate_in,
  input  wire logic [3:0]       lim_in,
  input  wire logic [ADC_W-1:0] cur_in,
  // Sense outputs
  output logic                  trip_out,
  output logic                  valid_out = 1'b0,
  output logic      [ADC_W-1:0] adc_out = '0
);
  localparam logic [ADC_W-1:0] THR [16] = '{12'h00A, 12'h014, 12'h028, 12'h050, 12'h078, 12'h0A0, 12'h0C8,
    12'h0F0, 12'h118, 12'h140, 12'h168, 12'h190, 12'h1B8, 12'h1E0, 12'h230, 12'h280};
  logic [1:0]       ph = 2'h0;
  // Current dies away once the bridge stops driving
  wire  [ADC_W-1:0] i_ph = (gate_in == GATE_RUN) ? cur_in : '0;
  assign trip_out = i_ph > THR[lim_in];
  always @(posedge clk_in) begin
    ph <= ph + 2'h1;
    valid_out <= ph == 2'h0;
    adc_out <= (ph == 2'h0) ? i_ph : ~adc_out;
  end
endmodule // lclf_stage_model

// ---- verif/tb_lclf_core.sv ----
// Self-checking bench for the lock unit.
// Assumes the design, stage model and checker are compiled first.
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_lclf_core
  import lclf_pkg::*;
;
  logic              clk_in    = 1'b0;
  logic              rst_b_in  = 1'b0;
  logic              cfg_wr_in = 1'b0;
  logic              clr       = 1'b0;
  logic [CFG_W-1:0]  wd        = '0;
  logic [RCNT_W-1:0] lim       = '0;
  logic [ADC_W-1:0]  cur       = '0;
  logic              trip, av, fn, lat;
  logic [ADC_W-1:0]  adc;
  logic [CFG_W-1:0]  rd;
  logic [3:0]        lcode;
  logic [RCNT_W-1:0] cnt;
  logic [1:0]        gate;
  int                mismatches = 0;
  int                tests_run  = 0;
  int                k;
  always #2 clk_in = ~clk_in;
  lclf_core #(.P_TICK_CYC(1)) u_lclf_core (.clk_in, .rst_b_in, .cfg_wr_in, .cfg_wdata_in(wd), .cfg_rdata_out(rd),
    .retry_attempt_limit_in(lim), .fault_clear_in(clr), .comp_trip_in(trip), .adc_valid_in(av),
    .adc_current_in(adc), .comp_limit_code_out(lcode), .fault_indicator_n_out(fn), .gate_mode_out(gate),
    .lock_latched_out(lat), .retry_count_out(cnt));
  lclf_stage_model u_lclf_stage_model (.clk_in, .gate_in(gate), .lim_in(lcode), .cur_in(cur), .trip_out(trip),
    .valid_out(av), .adc_out(adc));
  function automatic logic [31:0] cf(input logic [3:0] c, a, m, f, r);
    cf = {5'h00, c, a, m, f, r, 7'h00};
  endfunction
  task automatic wr(input logic [31:0] w);
    @(negedge clk_in);
    wd = w;
    cfg_wr_in = 1'b1;
    @(negedge clk_in);
    cfg_wr_in = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic wfn(input logic v, input int n);
    for (k = 0; k < n && fn !== v; k++)
      @(negedge clk_in);
  endtask
  task automatic clear_all();
    cur = '0;
    @(negedge clk_in);
    clr = 1'b1;
    @(negedge clk_in);
    clr = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic t_reset();
    repeat (5) @(negedge clk_in);
    `CHK("fault", 1'b1, fn)
    `CHK("gate", GATE_RUN, gate)
    `CHK("rdata", 32'h0, rd)
    rst_b_in = 1'b1;
  endtask
  task automatic t_cfg();
    wr(32'hFFFFFFFF);
    `CHK("rdata", 32'h7FFFFFFF, rd)
    `CHK("code", 4'hF, lcode)
    wr(32'h5A5A5A5A);
    `CHK("rdata", 32'h5A5A5A5A, rd)
    `CHK("code", 4'h4, lcode)
  endtask
  task automatic t_filter();
    wr(cf(4'h8, 4'hF, 4'h0, 4'h2, 4'h0));
    cur = 12'h12C;
    repeat (8) @(negedge clk_in);
    cur = '0;
    repeat (40) @(negedge clk_in);
    `CHK("short", 1'b1, fn)
    cur = 12'h12C;
    repeat (12) @(negedge clk_in);
    `CHK("early", 1'b1, fn)
    wfn(1'b0, 60);
    `CHK("fault", 1'b0, fn)
    `CHK("latch", 1'b1, lat)
    clear_all();
  endtask
  task automatic t_modes();
    logic [1:0] gs [9] = '{GATE_HIZ, GATE_HIZ, GATE_HSB, GATE_LSB, GATE_HIZ, GATE_HIZ, GATE_HSB, GATE_LSB, GATE_RUN};
    for (int i = 0; i < 9; i++) begin
      wr(cf(4'hF, 4'h8, i[3:0], 4'h0, 4'h0));
      cur = 12'h12C;
      wfn(1'b0, 100);
      `CHK("fault", 1'b0, fn)
      `CHK("gate", gs[i], gate)
      `CHK("latch", 1'(i < 8), lat)
      clear_all();
    end
  endtask
  task automatic t_disabled();
    logic [3:0] ms [3] = '{4'h9, 4'hA, 4'hC};
    for (int i = 0; i < 3; i++) begin
      wr(cf(4'h0, 4'h0, ms[i], 4'h0, 4'h0));
      cur = 12'h12C;
      repeat (40) @(negedge clk_in);
      `CHK("fault", 1'b1, fn)
      `CHK("gate", GATE_RUN, gate)
    end
    cur = '0;
  endtask
  task automatic t_retry();
    lim = 4'h1;
    wr(cf(4'hF, 4'h8, 4'h7, 4'h0, 4'h0));
    cur = 12'h12C;
    wfn(1'b0, 100);
    `CHK("gate", GATE_LSB, gate)
    `CHK("count", 4'h1, cnt)
    repeat (29000) @(negedge clk_in);
    `CHK("wait", 1'b0, fn)
    wfn(1'b1, 2000);
    `CHK("auto", 1'b1, fn)
    wfn(1'b0, 100);
    `CHK("latch", 1'b1, lat)
    `CHK("gate", GATE_LSB, gate)
    clear_all();
    lim = 4'h0;
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #240000;
    mismatches++;
    results();
  end
  initial begin
    t_reset();
    t_cfg();
    t_filter();
    t_modes();
    t_disabled();
    t_retry();
    results();
  end
endmodule // tb_lclf_core
